// file: include/ckl_pkg.sv
// Types shared by the L2 classification key builder.
package ckl_pkg;

  typedef struct packed {
    logic [15:0] tag_ethertype;
    logic [2:0] priority_bits;
    logic drop_eligible;
    logic [11:0] vlan_id;
  } ckl_tag_s;

  typedef struct packed {
    logic [5:0] phys_port;
    logic [5:0] loop_port;
    logic [5:0] src_port;
    logic is_loopback;
    logic is_inject;
    logic from_processor_port_a;
    logic from_processor_port_b;
    logic from_virtual_device_a;
    logic from_virtual_device_b;
    logic [4:0] frame_pipeline_point;
    logic [2:0] pipeline_action;
    logic [47:0] dmac;
    logic [47:0] smac;
    logic [2:0] tag_present;
    ckl_tag_s [2:0] tags;
    logic [2:0] cl_priority;
    logic cl_drop_eligible;
    logic [11:0] cl_vlan_id;
    logic is_ipv4;
    logic is_ipv6;
    logic [7:0] dip_top;
    logic [15:0] type_len;
  } ckl_frame_s;

  typedef struct packed {
    logic [52:0] ingress_port_bitmap;
    logic [1:0] port_bitmap_selector;
    logic dest_mac_multicast_flag;
    logic dest_mac_broadcast_flag;
    logic [2:0] outer_tag_proto_code;
    logic [2:0] outer_tag_priority;
    logic outer_tag_drop_eligible;
    logic [11:0] outer_tag_vlan_id;
    logic [2:0] second_tag_proto_code;
    logic [2:0] second_tag_priority;
    logic second_tag_drop_eligible;
    logic [11:0] second_tag_vlan_id;
    logic [2:0] third_tag_proto_code;
    logic [2:0] third_tag_priority;
    logic third_tag_drop_eligible;
    logic [11:0] third_tag_vlan_id;
    logic [47:0] dest_mac_field;
    logic [47:0] source_mac_field;
    logic ip_multicast_flag;
    logic ethertype_encoded_flag;
  } ckl_key_s;

endpackage

// file: include/ckl_regs.svh
// Register offsets, field positions, reset values and key encodings for the L2 key builder.
`ifndef CKL_REGS_SVH
`define CKL_REGS_SVH

// Register byte offsets on the AXI4-Lite slave.
`define CKL_OFS_CTRL 8'h00
`define CKL_OFS_CUSTOM1 8'h04
`define CKL_OFS_CUSTOM2 8'h08
`define CKL_OFS_CUSTOM3 8'h0c
`define CKL_OFS_FRAME_CNT 8'h10

// Control register bit positions.
`define CKL_CTRL_USE_CL_BIT 0
`define CKL_CTRL_MASQ_ENA_BIT 1
`define CKL_CTRL_CPU_ENA_BIT 2
`define CKL_CTRL_VD_ENA_BIT 3
`define CKL_CTRL_LBK_SEL3_BIT 4
`define CKL_CTRL_WIDTH 5

// Reset values.
`define CKL_CTRL_RST 5'h00
`define CKL_CUSTOM1_RST 16'h0000
`define CKL_CUSTOM2_RST 16'h0000
`define CKL_CUSTOM3_RST 16'h0000

// AXI response codes.
`define CKL_RESP_OKAY 2'h0
`define CKL_RESP_SLVERR 2'h2

// Port bitmap selector values.
`define CKL_SEL_PHYS 2'h0
`define CKL_SEL_LOOP 2'h1
`define CKL_SEL_MASQ 2'h2
`define CKL_SEL_SRC 2'h3

// Port bitmap field positions for selector value 3.
`define CKL_BM_PROC_A 0
`define CKL_BM_PROC_B 1
`define CKL_BM_VD_A 2
`define CKL_BM_VD_B 3
`define CKL_BM_SRC_LO 4
`define CKL_BM_SRC_HI 9
`define CKL_BM_PT_LO 44
`define CKL_BM_PT_HI 48
`define CKL_BM_ACT_LO 49
`define CKL_BM_ACT_HI 51
`define CKL_BM_RSVD 52

// Pipeline action code that marks an injected masqueraded frame.
`define CKL_ACT_INJ_MASQ 3'h1

// Tag protocol values and their key codes.
`define CKL_ETH_CTAG 16'h8100
`define CKL_ETH_STAG 16'h88a8
`define CKL_CODE_NONE 3'h0
`define CKL_CODE_CTAG 3'h1
`define CKL_CODE_STAG 3'h4
`define CKL_CODE_CUST1 3'h5
`define CKL_CODE_CUST2 3'h6
`define CKL_CODE_CUST3 3'h7

// Layer 2/3 constants.
`define CKL_MAC_MC_BIT 40
`define CKL_MAC_BCAST 48'hffffffffffff
`define CKL_IP4_MC_NIB 4'he
`define CKL_IP6_MC_BYTE 8'hff
`define CKL_ETYPE_MIN 16'h0600

`endif

// file: src/ckl_bitmap_build.sv
// Chooses the port bitmap selector and builds the 53-bit ingress port bitmap.
`timescale 1ns/1ps
`include "ckl_regs.svh"
module ckl_bitmap_build (
  input wire ckl_pkg::ckl_frame_s frame,
  input wire logic masq_ena,
  input wire logic cpu_ena,
  input wire logic vd_ena,
  input wire logic lbk_sel3_ena,
  output logic [1:0] selector,
  output logic [52:0] bitmap
);

  logic masq;
  logic from_proc;
  logic from_vd;

  assign masq = (frame.is_inject && (frame.src_port != frame.phys_port)) ||
                (frame.pipeline_action == `CKL_ACT_INJ_MASQ);
  assign from_proc = frame.from_processor_port_a | frame.from_processor_port_b;
  assign from_vd = frame.from_virtual_device_a | frame.from_virtual_device_b;

  // Later checks override earlier ones so the highest qualifying value wins.
  always_comb begin
    selector = `CKL_SEL_PHYS;
    if (frame.is_loopback) begin
      selector = `CKL_SEL_LOOP;
    end
    if (masq_ena && masq) begin
      selector = `CKL_SEL_MASQ;
    end
    if ((cpu_ena && from_proc) || (vd_ena && from_vd) || (lbk_sel3_ena && frame.is_loopback)) begin
      selector = `CKL_SEL_SRC;
    end
  end

  always_comb begin
    bitmap = '0;
    case (selector)
      `CKL_SEL_PHYS: bitmap = 53'h1 << frame.phys_port;
      `CKL_SEL_LOOP: bitmap = 53'h1 << frame.loop_port;
      `CKL_SEL_MASQ: bitmap = 53'h1 << frame.src_port;
      `CKL_SEL_SRC: begin
        bitmap[`CKL_BM_PROC_A] = frame.from_processor_port_a;
        bitmap[`CKL_BM_PROC_B] = frame.from_processor_port_b;
        bitmap[`CKL_BM_VD_A] = frame.from_virtual_device_a;
        bitmap[`CKL_BM_VD_B] = frame.from_virtual_device_b;
        bitmap[`CKL_BM_SRC_HI:`CKL_BM_SRC_LO] = frame.src_port;
        bitmap[`CKL_BM_PT_HI:`CKL_BM_PT_LO] = frame.frame_pipeline_point;
        bitmap[`CKL_BM_ACT_HI:`CKL_BM_ACT_LO] = frame.pipeline_action;
        bitmap[`CKL_BM_RSVD] = 1'b0;
      end
      default: bitmap = '0;
    endcase
  end

endmodule

// file: src/ckl_key_builder.sv
// Layer-2 classification key builder with an AXI4-Lite configuration slave.
//
// How it works
// - Selector 0: bitmap has one bit set, the receiving physical port.
// - Selector 1: bitmap bit of the port the frame was looped on.
// - Selector 2: bitmap bit of the masqueraded source port.
// - Selector 3: bits 0-3 flag processor port a/b, virtual device a/b.
// - Selector 3: source port in 4:9, point 44:48, action 49:51, 52 zero.
// - Multicast flag equals destination MAC bit 40.
// - Broadcast flag set when destination MAC is all ones.
// - Outer tag code: 0 none, 1 C-tag, 4 S-tag, 5-7 custom.
// - Second tag uses the same code, 0 when absent.
// - Third tag uses the same code, 0 when absent.
// - Outer priority from frame, or classified one when enabled.
// - Outer drop eligible from frame, or classified one when enabled.
// - Outer VLAN id from frame, or classified one when enabled.
// - Untagged frame gives outer VLAN id zero.
// - Second tag fields copied straight from the frame.
// - Third tag fields copied straight from the frame.
// - IP multicast: IPv4 top nibble 0xe, IPv6 top byte 0xff.
// - EtherType flag set when type/length is at least 0x600.
// - Selector: 0 default, 1 loopback, 2 masquerade, 3 processor/device (or loopback when bit 4 set); highest wins.
`timescale 1ns/1ps
`include "ckl_regs.svh"
module ckl_key_builder (
  input wire logic clk,
  input wire logic rst_n,
  input wire ckl_pkg::ckl_frame_s frame_i,
  input wire logic frame_valid,
  output logic frame_ready,
  output ckl_pkg::ckl_key_s key_o,
  output logic key_valid,
  input wire logic key_ready,
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);

  // Maps a tag's EtherType to its 3-bit key code.
  function automatic logic [2:0] tag_code(input logic present, input logic [15:0] etype,
                                          input logic [15:0] c1, input logic [15:0] c2,
                                          input logic [15:0] c3);
    logic [2:0] code;
    code = `CKL_CODE_NONE;
    if (present) begin
      if (etype == `CKL_ETH_CTAG) begin
        code = `CKL_CODE_CTAG;
      end else if (etype == `CKL_ETH_STAG) begin
        code = `CKL_CODE_STAG;
      end else if (etype == c1) begin
        code = `CKL_CODE_CUST1;
      end else if (etype == c2) begin
        code = `CKL_CODE_CUST2;
      end else if (etype == c3) begin
        code = `CKL_CODE_CUST3;
      end
    end
    return code;
  endfunction

  // Merges a write word into an old value under the byte strobes.
  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Configuration and status registers.
  logic [`CKL_CTRL_WIDTH-1:0] ctrl_q;
  logic [15:0] custom1_q;
  logic [15:0] custom2_q;
  logic [15:0] custom3_q;
  logic [31:0] frame_cnt_q;

  logic use_classified_outer_tag;
  assign use_classified_outer_tag = ctrl_q[`CKL_CTRL_USE_CL_BIT];

  // Key path.
  logic take;
  logic drain;
  logic valid_d;
  logic [1:0] sel_w;
  logic [52:0] bitmap_w;
  ckl_pkg::ckl_key_s key_d;
  ckl_pkg::ckl_key_s key_q;
  logic key_valid_q;
  logic frame_ready_q;

  assign take = frame_valid && frame_ready_q;
  assign drain = key_valid_q && key_ready;
  assign valid_d = take || (key_valid_q && !drain);

  ckl_bitmap_build u_bitmap (
    .frame(frame_i),
    .masq_ena(ctrl_q[`CKL_CTRL_MASQ_ENA_BIT]),
    .cpu_ena(ctrl_q[`CKL_CTRL_CPU_ENA_BIT]),
    .vd_ena(ctrl_q[`CKL_CTRL_VD_ENA_BIT]),
    .lbk_sel3_ena(ctrl_q[`CKL_CTRL_LBK_SEL3_BIT]),
    .selector(sel_w),
    .bitmap(bitmap_w)
  );

  always_comb begin
    key_d = '0;
    key_d.ingress_port_bitmap = bitmap_w;
    key_d.port_bitmap_selector = sel_w;
    key_d.dest_mac_multicast_flag = frame_i.dmac[`CKL_MAC_MC_BIT];
    key_d.dest_mac_broadcast_flag = (frame_i.dmac == `CKL_MAC_BCAST);
    key_d.outer_tag_proto_code = tag_code(frame_i.tag_present[0], frame_i.tags[0].tag_ethertype,
                                          custom1_q, custom2_q, custom3_q);
    key_d.second_tag_proto_code = tag_code(frame_i.tag_present[1], frame_i.tags[1].tag_ethertype,
                                           custom1_q, custom2_q, custom3_q);
    key_d.third_tag_proto_code = tag_code(frame_i.tag_present[2], frame_i.tags[2].tag_ethertype,
                                          custom1_q, custom2_q, custom3_q);
    if (use_classified_outer_tag) begin
      key_d.outer_tag_priority = frame_i.cl_priority;
      key_d.outer_tag_drop_eligible = frame_i.cl_drop_eligible;
      key_d.outer_tag_vlan_id = frame_i.cl_vlan_id;
    end else begin
      key_d.outer_tag_priority = frame_i.tags[0].priority_bits;
      key_d.outer_tag_drop_eligible = frame_i.tags[0].drop_eligible;
      key_d.outer_tag_vlan_id = frame_i.tags[0].vlan_id;
    end
    // An untagged frame always shows VLAN id zero, classified or not.
    if (!frame_i.tag_present[0]) begin
      key_d.outer_tag_vlan_id = 12'h000;
    end
    key_d.second_tag_priority = frame_i.tags[1].priority_bits;
    key_d.second_tag_drop_eligible = frame_i.tags[1].drop_eligible;
    key_d.second_tag_vlan_id = frame_i.tags[1].vlan_id;
    key_d.third_tag_priority = frame_i.tags[2].priority_bits;
    key_d.third_tag_drop_eligible = frame_i.tags[2].drop_eligible;
    key_d.third_tag_vlan_id = frame_i.tags[2].vlan_id;
    key_d.dest_mac_field = frame_i.dmac;
    key_d.source_mac_field = frame_i.smac;
    key_d.ip_multicast_flag = (frame_i.is_ipv4 && (frame_i.dip_top[7:4] == `CKL_IP4_MC_NIB)) ||
                              (frame_i.is_ipv6 && (frame_i.dip_top == `CKL_IP6_MC_BYTE));
    key_d.ethertype_encoded_flag = (frame_i.type_len >= `CKL_ETYPE_MIN);
  end

  // The key register only loads on an accepted frame and otherwise holds.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      key_q <= '0;
    end else if (take) begin
      key_q <= key_d;
    end
  end

  // A new frame is taken only in a cycle when the key slot is empty.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      key_valid_q <= 1'b0;
      frame_ready_q <= 1'b0;
    end else begin
      key_valid_q <= valid_d;
      frame_ready_q <= !valid_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_cnt_q <= 32'h00000000;
    end else if (take) begin
      frame_cnt_q <= frame_cnt_q + 32'h00000001;
    end
  end

  assign key_o = key_q;
  assign key_valid = key_valid_q;
  assign frame_ready = frame_ready_q;

  // AXI4-Lite write channel: address and data are held until both are in.
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic [7:0] waddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_do;

  assign wr_do = !awready_q && !wready_q && !bvalid_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awready_q <= 1'b1;
      waddr_q <= 8'h00;
    end else if (s_awvalid && awready_q) begin
      awready_q <= 1'b0;
      waddr_q <= s_awaddr;
    end else if (wr_do) begin
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wready_q <= 1'b1;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else if (s_wvalid && wready_q) begin
      wready_q <= 1'b0;
      wdata_q <= s_wdata;
      wstrb_q <= s_wstrb;
    end else if (wr_do) begin
      wready_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_q <= 1'b0;
      bresp_q <= `CKL_RESP_OKAY;
    end else if (wr_do) begin
      bvalid_q <= 1'b1;
      case (waddr_q)
        `CKL_OFS_CTRL, `CKL_OFS_CUSTOM1, `CKL_OFS_CUSTOM2, `CKL_OFS_CUSTOM3,
        `CKL_OFS_FRAME_CNT: bresp_q <= `CKL_RESP_OKAY;
        default: bresp_q <= `CKL_RESP_SLVERR;
      endcase
    end else if (bvalid_q && s_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Register writes; the frame counter is read-only and ignores writes.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `CKL_CTRL_RST;
      custom1_q <= `CKL_CUSTOM1_RST;
      custom2_q <= `CKL_CUSTOM2_RST;
      custom3_q <= `CKL_CUSTOM3_RST;
    end else if (wr_do) begin
      case (waddr_q)
        `CKL_OFS_CTRL: ctrl_q <= `CKL_CTRL_WIDTH'(merge_bytes({27'h0, ctrl_q}, wdata_q,
                                                              wstrb_q));
        `CKL_OFS_CUSTOM1: custom1_q <= 16'(merge_bytes({16'h0, custom1_q}, wdata_q, wstrb_q));
        `CKL_OFS_CUSTOM2: custom2_q <= 16'(merge_bytes({16'h0, custom2_q}, wdata_q, wstrb_q));
        `CKL_OFS_CUSTOM3: custom3_q <= 16'(merge_bytes({16'h0, custom3_q}, wdata_q, wstrb_q));
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  // AXI4-Lite read channel: data returned one cycle after the address is taken.
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `CKL_RESP_OKAY;
    end else if (s_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= `CKL_RESP_OKAY;
      case (s_araddr)
        `CKL_OFS_CTRL: rdata_q <= {27'h0, ctrl_q};
        `CKL_OFS_CUSTOM1: rdata_q <= {16'h0, custom1_q};
        `CKL_OFS_CUSTOM2: rdata_q <= {16'h0, custom2_q};
        `CKL_OFS_CUSTOM3: rdata_q <= {16'h0, custom3_q};
        `CKL_OFS_FRAME_CNT: rdata_q <= frame_cnt_q;
        default: begin
          rdata_q <= 32'h00000000;
          rresp_q <= `CKL_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  assign s_awready = awready_q;
  assign s_wready = wready_q;
  assign s_bvalid = bvalid_q;
  assign s_bresp = bresp_q;
  assign s_arready = arready_q;
  assign s_rvalid = rvalid_q;
  assign s_rdata = rdata_q;
  assign s_rresp = rresp_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  chk_sel_phys_bit: assert property (take && (sel_w == `CKL_SEL_PHYS) |=>
    key_q.ingress_port_bitmap == (53'h1 << $past(frame_i.phys_port)))
    else $error("bitmap does not mark the receiving port");

  chk_sel_loop_bit: assert property (take && (sel_w == `CKL_SEL_LOOP) |=>
    key_q.ingress_port_bitmap == (53'h1 << $past(frame_i.loop_port)))
    else $error("bitmap does not mark the loop port");

  chk_sel_masq_bit: assert property (take && (sel_w == `CKL_SEL_MASQ) |=>
    key_q.ingress_port_bitmap == (53'h1 << $past(frame_i.src_port)))
    else $error("bitmap does not mark the masqueraded port");

  chk_sel_src_flags: assert property (take && (sel_w == `CKL_SEL_SRC) |=>
    key_q.ingress_port_bitmap[0] == $past(frame_i.from_processor_port_a) &&
    key_q.ingress_port_bitmap[1] == $past(frame_i.from_processor_port_b) &&
    key_q.ingress_port_bitmap[2] == $past(frame_i.from_virtual_device_a) &&
    key_q.ingress_port_bitmap[3] == $past(frame_i.from_virtual_device_b))
    else $error("source flags wrong in bitmap");

  chk_sel_src_fields: assert property (take && (sel_w == `CKL_SEL_SRC) |=>
    key_q.ingress_port_bitmap[9:4] == $past(frame_i.src_port) &&
    key_q.ingress_port_bitmap[51:49] == $past(frame_i.pipeline_action) &&
    !key_q.ingress_port_bitmap[52])
    else $error("source fields wrong in bitmap");

  chk_mac_flags: assert property (take |=>
    key_q.dest_mac_multicast_flag == $past(frame_i.dmac[40]) &&
    key_q.dest_mac_broadcast_flag == ($past(frame_i.dmac) == 48'hffffffffffff))
    else $error("destination MAC flags wrong");

  chk_outer_code: assert property (take && !frame_i.tag_present[0] |=>
    key_q.outer_tag_proto_code == 3'h0 && key_q.outer_tag_vlan_id == 12'h000)
    else $error("untagged frame gives nonzero outer code or id");

  chk_ctag_code: assert property (take && frame_i.tag_present[1] &&
    frame_i.tags[1].tag_ethertype == 16'h8100 |=> key_q.second_tag_proto_code == 3'h1)
    else $error("second tag C-tag code wrong");

  chk_classified_use: assert property (take && use_classified_outer_tag |=>
    key_q.outer_tag_priority == $past(frame_i.cl_priority) &&
    key_q.outer_tag_drop_eligible == $past(frame_i.cl_drop_eligible))
    else $error("classified outer tag not used");

  chk_etype_flag: assert property (take |=>
    key_q.ethertype_encoded_flag == ($past(frame_i.type_len) >= 16'h0600))
    else $error("EtherType flag wrong");

  chk_loop_priority: assert property (take && frame_i.is_loopback |=>
    key_q.port_bitmap_selector != 2'h0)
    else $error("loopback frame kept default selector");

  chk_key_hold: assert property (key_valid_q && !key_ready |=>
    key_valid_q && $stable(key_q))
    else $error("key changed before it was accepted");

endmodule

// file: verif/ckl_key_builder_tb_top.sv
// Self-checking bench for the L2 classification key builder.
`timescale 1ns/1ps
`include "ckl_regs.svh"
module ckl_key_builder_tb_top;
  typedef struct packed {
    logic [47:0] dmac;
    logic [15:0] tl;
    logic v4;
    logic v6;
    logic [7:0] dip;
    logic [3:0] exp;
  } ckl_row_s;
  localparam ckl_row_s rows [5] = '{
    '{48'h010000000000, 16'h05ff, 1'b0, 1'b0, 8'h00, 4'h8},
    '{48'hffffffffffff, 16'h0600, 1'b1, 1'b0, 8'he0, 4'hf},
    '{48'hfeffffffffff, 16'h0800, 1'b1, 1'b0, 8'hf0, 4'h1},
    '{48'h000000000001, 16'h86dd, 1'b0, 1'b1, 8'hff, 4'h3},
    '{48'h0100000000ff, 16'h86dd, 1'b0, 1'b1, 8'hfe, 4'h9}};
  logic [15:0] ets [6] = '{16'h8100, 16'h88a8, 16'h9100, 16'h9200, 16'h1234, 16'h0800};
  logic [2:0] codes [6] = '{3'h1, 3'h4, 3'h5, 3'h6, 3'h7, 3'h0};
  logic clk, rst_n, frame_valid, frame_ready, key_valid, key_ready, stall;
  ckl_pkg::ckl_frame_s frame_i, f;
  ckl_pkg::ckl_key_s key_o, k, got_key;
  logic [7:0] got_cnt, s_awaddr, s_araddr;
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready;
  logic [31:0] s_wdata, s_rdata, rd;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp, rsp;
  logic [52:0] b3;
  int fails, checks_done, i, nsent;

  ckl_key_builder u_ckl_key_builder (.clk, .rst_n, .frame_i, .frame_valid, .frame_ready,
    .key_o, .key_valid, .key_ready, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
    .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
    .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready);
  ckl_match_engine u_ckl_match_engine (.clk, .rst_n, .key_o, .key_valid, .stall,
    .key_ready, .got_key, .got_cnt);

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic tmo;
    fails++;
    $display("mismatch at %0t: wait ran out", $time);
    wrap_up();
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // Address and data are offered together and each dropped once its ready is seen.
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    for (n = 0; n < 50 && !(s_bvalid && !s_awvalid && !s_wvalid); n++) begin
      @(posedge clk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end
    if (n == 50) tmo();
    rsp = s_bresp;
    s_bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a);
    int n;
    @(posedge clk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    for (n = 0; n < 50 && !(s_rvalid && !s_arvalid); n++) begin
      @(posedge clk);
      if (s_arready) s_arvalid <= 1'b0;
    end
    if (n == 50) tmo();
    rd = s_rdata;
    rsp = s_rresp;
    s_rready <= 1'b0;
  endtask

  task automatic send(input ckl_pkg::ckl_frame_s fr);
    int n;
    logic [7:0] c0;
    c0 = got_cnt;
    @(posedge clk);
    frame_i <= fr;
    frame_valid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (frame_ready) break;
    end
    if (n == 50) tmo();
    frame_valid <= 1'b0;
    nsent++;
    for (n = 0; n < 50 && got_cnt == c0; n++) @(posedge clk);
    if (n == 50) tmo();
    k = got_key;
  endtask

  task automatic selchk(input logic [31:0] c, input logic [1:0] es, input logic [52:0] eb);
    axw(`CKL_OFS_CTRL, c);
    send(f);
    chk(64'(k.port_bitmap_selector), 64'(es));
    chk(64'(k.ingress_port_bitmap), 64'(eb));
  endtask

  initial begin
    {rst_n, frame_valid, stall, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    {frame_i, f, s_awaddr, s_araddr, s_wdata} = '0;
    s_wstrb = 4'hf;
    b3 = (53'h5 << 49) | (53'h13 << 44) | (53'h9 << 4);
    repeat (3) @(posedge clk);
    chk(64'({key_valid, frame_ready}), 64'h0);
    rst_n <= 1'b1;
    axw(`CKL_OFS_CUSTOM1, 32'habcd9100);
    axw(`CKL_OFS_CUSTOM2, 32'h9200);
    axw(`CKL_OFS_CUSTOM3, 32'h1234);
    axr(`CKL_OFS_CUSTOM1);
    chk(64'(rd), 64'h9100);
    axr(8'h40);
    chk(64'(rsp), 64'(`CKL_RESP_SLVERR));
    $display("registers done");
    for (i = 0; i < 5; i++) begin
      f = '0;
      f.dmac = rows[i].dmac;
      f.smac = ~rows[i].dmac;
      f.type_len = rows[i].tl;
      f.is_ipv4 = rows[i].v4;
      f.is_ipv6 = rows[i].v6;
      f.dip_top = rows[i].dip;
      send(f);
      chk(64'({k.dest_mac_multicast_flag, k.dest_mac_broadcast_flag, k.ip_multicast_flag,
        k.ethertype_encoded_flag}), 64'(rows[i].exp));
      chk(64'(k.source_mac_field ^ k.dest_mac_field), 64'hffffffffffff);
    end
    $display("flag rows done");
    for (i = 0; i < 6; i++) begin
      f = '0;
      f.tag_present = 3'h7;
      f.tags[0] = {ets[i], 3'h5, 1'b0, 12'habc};
      f.tags[1] = {ets[(i + 1) % 6], 3'h2, 1'b1, 12'h123};
      f.tags[2] = {ets[(i + 2) % 6], 3'h6, 1'b1, 12'hfed};
      f.cl_priority = 3'h1;
      f.cl_drop_eligible = 1'b1;
      f.cl_vlan_id = 12'h777;
      send(f);
      chk(64'({k.outer_tag_proto_code, k.second_tag_proto_code, k.third_tag_proto_code}),
        64'({codes[i], codes[(i + 1) % 6], codes[(i + 2) % 6]}));
      chk(64'({k.outer_tag_priority, k.outer_tag_drop_eligible, k.outer_tag_vlan_id}),
        64'haabc);
      chk(64'({k.second_tag_priority, k.second_tag_drop_eligible, k.second_tag_vlan_id}),
        64'(f.tags[1][15:0]));
      chk(64'({k.third_tag_priority, k.third_tag_drop_eligible, k.third_tag_vlan_id}),
        64'(f.tags[2][15:0]));
    end
    axw(`CKL_OFS_CTRL, 32'h1);
    send(f);
    chk(64'({k.outer_tag_priority, k.outer_tag_drop_eligible, k.outer_tag_vlan_id}),
      64'h3777);
    f.tag_present = 3'h1;
    send(f);
    chk(64'({k.second_tag_proto_code, k.third_tag_proto_code}), 64'h0);
    f.tag_present = 3'h0;
    send(f);
    chk(64'({k.outer_tag_proto_code, k.outer_tag_vlan_id}), 64'h0);
    $display("tag cases done");
    f = '0;
    f.phys_port = 6'd5;
    f.loop_port = 6'd7;
    f.src_port = 6'd9;
    f.frame_pipeline_point = 5'h13;
    f.pipeline_action = 3'h5;
    selchk(32'h0, 2'h0, 53'h1 << 5);
    f.is_loopback = 1'b1;
    selchk(32'h0, 2'h1, 53'h1 << 7);
    f.is_inject = 1'b1;
    selchk(32'h2, 2'h2, 53'h1 << 9);
    selchk(32'h0, 2'h1, 53'h1 << 7);
    f.from_processor_port_a = 1'b1;
    f.from_processor_port_b = 1'b1;
    selchk(32'h6, 2'h3, b3 | 53'h3);
    f.is_inject = 1'b0;
    f.from_processor_port_a = 1'b0;
    f.from_processor_port_b = 1'b0;
    f.from_virtual_device_a = 1'b1;
    f.from_virtual_device_b = 1'b1;
    selchk(32'h8, 2'h3, b3 | 53'hc);
    f.from_virtual_device_a = 1'b0;
    f.from_virtual_device_b = 1'b0;
    selchk(32'h10, 2'h3, b3);
    f.pipeline_action = `CKL_ACT_INJ_MASQ;
    selchk(32'h2, 2'h2, 53'h1 << 9);
    $display("selector cases done");
    stall <= 1'b1;
    f.dmac = 48'h123456789abc;
    fork
      send(f);
      begin
        repeat (8) @(posedge clk);
        chk(64'({key_valid, frame_ready}), 64'h2);
        chk(64'(key_o.dest_mac_field), 64'(f.dmac));
        stall <= 1'b0;
      end
    join
    chk(64'(k.dest_mac_field), 64'(f.dmac));
    axw(`CKL_OFS_FRAME_CNT, 32'h0);
    chk(64'(rsp), 64'(`CKL_RESP_OKAY));
    axr(`CKL_OFS_FRAME_CNT);
    chk(64'(rd), 64'(nsent));
    axw(8'h40, 32'h0);
    chk(64'(rsp), 64'(`CKL_RESP_SLVERR));
    s_wstrb <= 4'h1;
    axw(`CKL_OFS_CUSTOM2, 32'hffff0055);
    axr(`CKL_OFS_CUSTOM2);
    chk(64'(rd), 64'h9255);
    $display("stall and count done");
    rst_n <= 1'b0;
    s_wstrb <= 4'hf;
    repeat (2) @(posedge clk);
    chk(64'({key_valid, frame_ready, s_awready, s_arready, s_bvalid, s_rvalid}), 64'h0c);
    rst_n <= 1'b1;
    axr(`CKL_OFS_CUSTOM2);
    chk(64'(rd), 64'h0);
    axr(`CKL_OFS_CTRL);
    chk(64'(rd), 64'h0);
    $display("reset cases done");
    wrap_up();
  end
endmodule

// file: verif/ckl_match_engine.sv
// Match engine stand-in that takes keys at once or stalls on command.
`timescale 1ns/1ps
module ckl_match_engine (
  input wire logic clk,
  input wire logic rst_n,
  input wire ckl_pkg::ckl_key_s key_o,
  input wire logic key_valid,
  input wire logic stall,
  output logic key_ready,
  output ckl_pkg::ckl_key_s got_key,
  output logic [7:0] got_cnt
);
  assign key_ready = rst_n && !stall;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      got_key <= '0;
      got_cnt <= 8'h00;
    end else if (key_valid && key_ready) begin
      got_key <= key_o;
      got_cnt <= got_cnt + 8'h01;
    end
  end
endmodule
